// *** shared/modem_mode_defs.svh ***
`ifndef MODEM_MODE_DEFS_SVH
`define MODEM_MODE_DEFS_SVH

// ********************************************************
// raw test/operate selector codes, any other code is reset
// ********************************************************
`define SEL_WIDTH 3
`define SEL_OPERATE 3'h0
`define SEL_LOCAL 3'h1
`define SEL_TERM 3'h2
`define SEL_CHTX 3'h3
`define SEL_REMRX 3'h4

// ********************************************************
// timing
// ********************************************************
`define CLK_MHZ 200
`define BLANK_MS 200
`define BLANK_CYCLES (`BLANK_MS * `CLK_MHZ * 1000)
`define BLINK_MS 500
`define BLINK_CYCLES (`BLINK_MS * `CLK_MHZ * 1000)

// ********************************************************
// signal quality display
// ********************************************************
`define QUAL_WIDTH 6
`define QUAL_MAX 6'h32

`endif

// *** shared/modem_mode_pkg.sv ***
`default_nettype none
package modem_mode_pkg;

  // decoded selector state
  typedef enum logic [2:0] {
    MODE_OPERATE,
    MODE_RESET,
    MODE_LOCAL,
    MODE_TERM,
    MODE_CHTX,
    MODE_REMRX
  } mode_t;

  // internal control lines toward line side and interface
  typedef struct packed {
    logic rtsOn;
    logic sendData;
    logic twoWireSelect;
    logic wrapRelay;
    logic eqBypass;
    logic clampInterface;
    logic lineReadyOut;
    logic forceDtrOff;
    logic forceDtrOn;
  } ctrl_t;

  // decoded selector lines, one hot
  typedef struct packed {
    logic operate;
    logic reset;
    logic localLoopTest;
    logic terminalLoopTest;
    logic channelTransmitTest;
    logic remoteReceiveTest;
  } sel_lines_t;

endpackage : modem_mode_pkg
`default_nettype wire

// *** hw/blank_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "modem_mode_defs.svh"

module blank_timer #(
  parameter int CYCLES = `BLANK_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic restart,
  output logic active
);

  localparam int CW = $clog2(CYCLES + 1);

  generate
    if (CYCLES < 2) begin : g_bad
      $error("blank_timer needs at least two cycles");
    end
  endgenerate

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;

  // every new space reloads, so a burst keeps the lamp dark
  always_comb begin
    count_next = count_reg;
    if (restart) begin
      count_next = CW'(CYCLES); // RULE16
    end else if (count_reg != '0) begin
      count_next = count_reg - CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign active = (count_reg != '0);

  AST_RESTART_ARMS: assert property (@(posedge clock) disable iff (!nrst)
    restart |=> active) // RULE16
    else $error("blank interval not started by a space");

endmodule : blank_timer
`default_nettype wire

// *** hw/modem_test_mode_control.sv ***
// Summary of operation
// RULE1: voice position stops auto answer, ignores terminal ready
// RULE2: selector changes pass reset; some keep connection
// RULE3: decode one-hot lines for operate, tests, reset
// RULE4: operate follows terminal, strap and data set ready
// RULE5: reset clamps interface, marks data, steers forced ready
// RULE6: local loop forces send, wraps, clamps, four-wire
// RULE7: terminal loop follows terminal with wrap, unclamped
// RULE8: channel tests clamp, force ready on, bypass at 1200
// RULE9: transmit test marks; receive test echoes received data
// RULE10: ready lamp mirrors ready, dark in terminal loop
// RULE11: ready lamp blinks in operate, off elsewhere
// RULE12: operate lamp shows mark, in looped tests a space blanks it 200 ms
// RULE13: looped tests keep operate lamp lit without errors
// RULE14: quality zero without carrier, capped at 50 except in local and terminal loop
// RULE15: clamped interface ignores the terminal completely
// RULE16: blanking counted on clock, restarted by each space
`timescale 1ns/10ps
`default_nettype none
`include "modem_mode_defs.svh"

module modem_test_mode_control #(
  parameter int BLANK_CYCLES = `BLANK_CYCLES,
  parameter int BLINK_CYCLES = `BLINK_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [`SEL_WIDTH-1:0] selectorPos,
  input wire logic voicePosition,
  input wire logic twoWireStrap,
  input wire logic rate1200,
  input wire logic dataSetReady,
  input wire logic clampResync,
  input wire logic carrierDetect,
  input wire logic rxData,
  input wire logic [`QUAL_WIDTH-1:0] qualityIn,
  input wire logic dteRts,
  input wire logic dteTxData,
  input wire logic dteDtr,
  input wire logic dteTest,
  output modem_mode_pkg::ctrl_t ctrl,
  output modem_mode_pkg::sel_lines_t selLines,
  output logic autoAnswerEnable,
  output logic dtrAccepted,
  output logic connDrop,
  output logic readyLamp,
  output logic operateLamp,
  output logic [`QUAL_WIDTH-1:0] qualityOut
);

  localparam int BW = $clog2(BLINK_CYCLES + 1);

  generate
    if (BLINK_CYCLES < 2 || BLANK_CYCLES < 2) begin : g_bad
      $error("blink and blank counts must be at least two");
    end
  endgenerate

  // ********************************************************
  // selector decode and sequencing
  // ********************************************************

  function automatic modem_mode_pkg::mode_t decodeSel(
    input logic [`SEL_WIDTH-1:0] pos);
    case (pos)
      `SEL_OPERATE: decodeSel = modem_mode_pkg::MODE_OPERATE;
      `SEL_LOCAL: decodeSel = modem_mode_pkg::MODE_LOCAL;
      `SEL_TERM: decodeSel = modem_mode_pkg::MODE_TERM;
      `SEL_CHTX: decodeSel = modem_mode_pkg::MODE_CHTX;
      `SEL_REMRX: decodeSel = modem_mode_pkg::MODE_REMRX;
      default: decodeSel = modem_mode_pkg::MODE_RESET;
    endcase
  endfunction : decodeSel

  // positions across which a switched connection survives
  function automatic logic keepsLine(input modem_mode_pkg::mode_t m);
    keepsLine = (m == modem_mode_pkg::MODE_OPERATE) ||
                (m == modem_mode_pkg::MODE_CHTX) ||
                (m == modem_mode_pkg::MODE_REMRX);
  endfunction : keepsLine

  modem_mode_pkg::mode_t target;
  modem_mode_pkg::mode_t curMode_reg, curMode_next;
  modem_mode_pkg::mode_t lastMode_reg, lastMode_next;
  logic connDrop_reg, connDrop_next;

  assign target = decodeSel(selectorPos);

  // a jump between two positions is split by one reset cycle
  always_comb begin
    curMode_next = target;
    lastMode_next = lastMode_reg;
    connDrop_next = 1'b0;
    if (curMode_reg != modem_mode_pkg::MODE_RESET &&
        target != curMode_reg) begin
      curMode_next = modem_mode_pkg::MODE_RESET; // RULE2
    end
    if (curMode_reg == modem_mode_pkg::MODE_RESET &&
        curMode_next != modem_mode_pkg::MODE_RESET) begin
      lastMode_next = curMode_next;
      // RULE2
      connDrop_next = (curMode_next != lastMode_reg) &&
                      !(keepsLine(curMode_next) && keepsLine(lastMode_reg));
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      curMode_reg <= modem_mode_pkg::MODE_RESET;
      lastMode_reg <= modem_mode_pkg::MODE_OPERATE;
      connDrop_reg <= 1'b0;
    end else begin
      curMode_reg <= curMode_next;
      lastMode_reg <= lastMode_next;
      connDrop_reg <= connDrop_next;
    end
  end

  // one line per state, so exactly one is ever high
  always_comb begin
    selLines = '0;
    case (curMode_reg)
      modem_mode_pkg::MODE_OPERATE: selLines.operate = 1'b1; // RULE3
      modem_mode_pkg::MODE_LOCAL: selLines.localLoopTest = 1'b1;
      modem_mode_pkg::MODE_TERM: selLines.terminalLoopTest = 1'b1;
      modem_mode_pkg::MODE_CHTX: selLines.channelTransmitTest = 1'b1;
      modem_mode_pkg::MODE_REMRX: selLines.remoteReceiveTest = 1'b1;
      default: selLines.reset = 1'b1;
    endcase
  end

  assign connDrop = connDrop_reg;

  // ********************************************************
  // control lines
  // ********************************************************

  modem_mode_pkg::ctrl_t ctrl_reg, ctrl_next;
  logic termLike;
  logic farSide;

  // interface test from the terminal acts like terminal loop
  assign termLike = selLines.terminalLoopTest ||
                    (selLines.operate && dteTest);
  assign farSide = (lastMode_reg == modem_mode_pkg::MODE_CHTX) ||
                   (lastMode_reg == modem_mode_pkg::MODE_REMRX);

  always_comb begin
    ctrl_next = '0;
    ctrl_next.twoWireSelect = twoWireStrap;
    ctrl_next.sendData = 1'b1; // mark unless a mode says otherwise
    if (termLike) begin
      ctrl_next.rtsOn = dteRts; // RULE7
      ctrl_next.sendData = dteTxData;
      ctrl_next.twoWireSelect = 1'b0;
      ctrl_next.wrapRelay = 1'b1;
      ctrl_next.eqBypass = 1'b1;
      ctrl_next.lineReadyOut = clampResync;
      ctrl_next.forceDtrOff = 1'b1;
    end else begin
      case (curMode_reg)
        modem_mode_pkg::MODE_OPERATE: begin
          ctrl_next.rtsOn = dteRts; // RULE4
          ctrl_next.sendData = dteTxData;
          ctrl_next.lineReadyOut = dataSetReady;
        end
        modem_mode_pkg::MODE_LOCAL: begin
          ctrl_next.rtsOn = 1'b1; // RULE6
          ctrl_next.twoWireSelect = 1'b0;
          ctrl_next.wrapRelay = 1'b1;
          ctrl_next.eqBypass = 1'b1;
          ctrl_next.clampInterface = 1'b1;
          ctrl_next.lineReadyOut = clampResync;
          ctrl_next.forceDtrOff = 1'b1;
        end
        modem_mode_pkg::MODE_CHTX, modem_mode_pkg::MODE_REMRX: begin
          ctrl_next.clampInterface = 1'b1; // RULE8
          ctrl_next.forceDtrOn = 1'b1;
          ctrl_next.eqBypass = rate1200;
          ctrl_next.lineReadyOut = dataSetReady;
          ctrl_next.rtsOn = 1'b1; // RULE9
          if (curMode_reg == modem_mode_pkg::MODE_REMRX) begin
            ctrl_next.rtsOn = !twoWireStrap;
            ctrl_next.sendData = rxData;
          end
        end
        default: begin
          // RULE5
          ctrl_next.clampInterface = 1'b1;
          ctrl_next.forceDtrOff = !farSide;
          ctrl_next.forceDtrOn = farSide;
        end
      endcase
    end
  end

  logic autoAnswer_reg, autoAnswer_next;
  logic dtrAcc_reg, dtrAcc_next;

  // handset use and a clamped interface both shut the terminal out
  always_comb begin
    autoAnswer_next = !voicePosition; // RULE1
    dtrAcc_next = dteDtr && !voicePosition &&
                  !ctrl_next.clampInterface; // RULE15
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_reg <= '0;
      autoAnswer_reg <= 1'b0;
      dtrAcc_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      autoAnswer_reg <= autoAnswer_next;
      dtrAcc_reg <= dtrAcc_next;
    end
  end

  assign ctrl = ctrl_reg;
  assign autoAnswerEnable = autoAnswer_reg;
  assign dtrAccepted = dtrAcc_reg;

  // ********************************************************
  // front panel indicators
  // ********************************************************

  logic [BW-1:0] blinkCnt_reg, blinkCnt_next;
  logic blinkPhase_reg, blinkPhase_next;
  logic loopMode;
  logic blanking;
  logic ready_reg, ready_next;
  logic operLamp_reg, operLamp_next;
  logic [`QUAL_WIDTH-1:0] qual_reg, qual_next;

  // free running half period divider for the ready blink
  always_comb begin
    blinkCnt_next = blinkCnt_reg - BW'(1);
    blinkPhase_next = blinkPhase_reg;
    if (blinkCnt_reg == '0) begin
      blinkCnt_next = BW'(BLINK_CYCLES - 1);
      blinkPhase_next = !blinkPhase_reg;
    end
  end

  assign loopMode = selLines.localLoopTest ||
                    selLines.channelTransmitTest ||
                    selLines.remoteReceiveTest;

  blank_timer #(
    .CYCLES(BLANK_CYCLES)
  ) u_blank (
    .clock(clock),
    .nrst(nrst),
    .restart(loopMode && !rxData), // RULE12
    .active(blanking)
  );

  // the lamp is dark for the whole interval, even if marks return
  always_comb begin
    // RULE10 RULE11
    ready_next = selLines.operate && dataSetReady && blinkPhase_reg;
    // RULE13
    operLamp_next = rxData && !(loopMode && blanking);
    qual_next = '0;
    if (carrierDetect) begin // RULE14
      if (selLines.operate || selLines.channelTransmitTest ||
          selLines.remoteReceiveTest) begin
        qual_next = (qualityIn > `QUAL_MAX) ? `QUAL_MAX : qualityIn;
      end else if (!selLines.reset) begin
        qual_next = qualityIn;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      blinkCnt_reg <= BW'(BLINK_CYCLES - 1);
      blinkPhase_reg <= 1'b0;
      ready_reg <= 1'b0;
      operLamp_reg <= 1'b0;
      qual_reg <= '0;
    end else begin
      blinkCnt_reg <= blinkCnt_next;
      blinkPhase_reg <= blinkPhase_next;
      ready_reg <= ready_next;
      operLamp_reg <= operLamp_next;
      qual_reg <= qual_next;
    end
  end

  assign readyLamp = ready_reg;
  assign operateLamp = operLamp_reg;
  assign qualityOut = qual_reg;

  // ********************************************************
  // checks
  // ********************************************************

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence spaceSeen;
    loopMode && !rxData;
  endsequence

  sequence stillLooped;
    loopMode;
  endsequence

  AST_VOICE_BLOCKS: assert property (voicePosition |=> // RULE1
    !autoAnswerEnable && !dtrAccepted)
    else $error("voice position did not block the terminal");
  AST_VIA_RESET: assert property (
    curMode_reg != modem_mode_pkg::MODE_RESET |=> // RULE2
    (curMode_reg == $past(curMode_reg) ||
     curMode_reg == modem_mode_pkg::MODE_RESET))
    else $error("selector skipped the reset state");
  AST_KEEP_LINE: assert property (
    curMode_reg == modem_mode_pkg::MODE_RESET && // RULE2
    lastMode_reg == modem_mode_pkg::MODE_CHTX &&
    target == modem_mode_pkg::MODE_REMRX |=> !connDrop)
    else $error("connection dropped between channel tests");
  AST_ONE_HOT: assert property ($onehot(selLines)) // RULE3
    else $error("selector lines not one hot");
  AST_RESET_CLAMP: assert property (
    curMode_reg == modem_mode_pkg::MODE_RESET |=> // RULE5
    ctrl.clampInterface && !ctrl.rtsOn && ctrl.sendData &&
    !ctrl.lineReadyOut && (ctrl.forceDtrOn != ctrl.forceDtrOff))
    else $error("reset position controls wrong");
  AST_LOCAL_WRAP: assert property (
    curMode_reg == modem_mode_pkg::MODE_LOCAL |=> // RULE6
    ctrl.wrapRelay && ctrl.eqBypass && ctrl.clampInterface &&
    !ctrl.twoWireSelect && ctrl.rtsOn)
    else $error("local loop controls wrong");
  AST_ECHO_RX: assert property (
    curMode_reg == modem_mode_pkg::MODE_REMRX |=> // RULE9
    ctrl.sendData == $past(rxData))
    else $error("remote receive test did not echo data");
  AST_EQ_1200: assert property (
    curMode_reg == modem_mode_pkg::MODE_CHTX |=> // RULE8
    ctrl.eqBypass == $past(rate1200) && ctrl.forceDtrOn)
    else $error("equalizer bypass wrong in channel test");
  AST_TERM_DARK: assert property (selLines.terminalLoopTest |=> // RULE10
    !readyLamp)
    else $error("ready lamp lit in terminal loop");
  AST_SPACE_BLANKS: assert property (spaceSeen ##1 stillLooped |-> // RULE12
    !operateLamp ##1 !operateLamp)
    else $error("space did not blank the operate lamp");
  AST_QUAL_ZERO: assert property (!carrierDetect |=> // RULE14
    qualityOut == '0)
    else $error("quality nonzero without carrier");

endmodule : modem_test_mode_control
`default_nettype wire

// *** tb/dte_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// terminal side stand-in
// ****************************************
module dte_model (
  input wire logic clock,
  input wire logic active,
  output logic rts,
  output logic txData,
  output logic dtr,
  output logic test
);
  // new levels just after each edge, held for the whole cycle
  initial begin
    {rts, txData, dtr, test} = 4'h0;
    forever begin
      @(posedge clock);
      #1;
      if (active) begin
        {rts, txData, dtr} = 3'($urandom);
        test = ($urandom % 6) == 0;
      end
    end
  end
endmodule : dte_model

`default_nettype wire

// *** tb/modem_test_mode_control_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "modem_mode_defs.svh"

// ****************************************
// bench top with reference model
// ****************************************
module modem_test_mode_control_tb;
  localparam int BLANK = 20;
  localparam int BLINK = 8;
  logic clock, nrst, voice, strap, r1200, dsr, resync, carrier, rxData;
  logic [`SEL_WIDTH-1:0] sel;
  logic [`QUAL_WIDTH-1:0] qIn, qOut;
  logic rts, txd, dtr, tst, dteOn, aae, dtrAcc, drop, rdyLamp, opLamp;
  modem_mode_pkg::ctrl_t ctrl;
  modem_mode_pkg::sel_lines_t selLines;
  int nErrors, samplesChecked, cycles, md, lastMd, since, bcnt;
  bit checkOn, seen0, seen1, bph;

  modem_test_mode_control #(
    .BLANK_CYCLES(BLANK),
    .BLINK_CYCLES(BLINK)
  ) u_dut (
    .clock(clock),
    .nrst(nrst),
    .selectorPos(sel),
    .voicePosition(voice),
    .twoWireStrap(strap),
    .rate1200(r1200),
    .dataSetReady(dsr),
    .clampResync(resync),
    .carrierDetect(carrier),
    .rxData(rxData),
    .qualityIn(qIn),
    .dteRts(rts),
    .dteTxData(txd),
    .dteDtr(dtr),
    .dteTest(tst),
    .ctrl(ctrl),
    .selLines(selLines),
    .autoAnswerEnable(aae),
    .dtrAccepted(dtrAcc),
    .connDrop(drop),
    .readyLamp(rdyLamp),
    .operateLamp(opLamp),
    .qualityOut(qOut)
  );

  dte_model u_dte (
    .clock(clock),
    .active(dteOn),
    .rts(rts),
    .txData(txd),
    .dtr(dtr),
    .test(tst)
  );

  task automatic check(input logic [8:0] got, input logic [8:0] exp,
                       input string what);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic completeRun;
    $display("errors %0d checks %0d", nErrors, samplesChecked);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : completeRun

  // control lines per mode; 2 also stands for interface test in operate
  function automatic logic [8:0] ctrlExp(input int m);
    logic ch;
    ch = lastMd == 3 || lastMd == 4;
    case (m)
      0: return {rts, txd, strap, 3'h0, dsr, 2'h0};
      1: return {2'h3, 1'h0, 3'h7, resync, 2'h2};
      2: return {rts, txd, 1'h0, 3'h6, resync, 2'h2};
      3: return {2'h3, strap, 1'h0, r1200, 1'h1, dsr, 2'h1};
      4: return {~strap, rxData, strap, 1'h0, r1200, 1'h1, dsr, 2'h1};
      default: return {2'h1, strap, 3'h1, 1'h0, ~ch, ch};
    endcase
  endfunction : ctrlExp

  function automatic logic [5:0] selExp(input int m);
    if (m == 0) return 6'h20;
    if (m == 5) return 6'h10;
    return 6'h10 >> m;
  endfunction : selExp

  // reference: expectations from the state before each edge
  always @(posedge clock) begin
    int e, t;
    logic [8:0] ec;
    logic [5:0] eq;
    logic dE, dtrE, vo, lE, rE, keep;
    e = (md == 0 && tst) ? 2 : md;
    ec = ctrlExp(e);
    eq = (md == 1 || md == 2 || qIn < `QUAL_MAX) ? qIn : `QUAL_MAX;
    if (md == 5 || !carrier) eq = 6'h0;
    dtrE = dtr && !voice && (e == 0 || e == 2);
    vo = voice;
    // ready lamp blinks with half period BLINK while operate sees ready
    rE = md == 0 && dsr && bph;
    if (bcnt == 0) begin
      bcnt = BLINK - 1;
      bph = !bph;
    end else begin
      bcnt--;
    end
    since++;
    lE = rxData;
    // a space darkens the lamp at its own edge and for BLANK more
    if (md == 1 || md == 3 || md == 4) begin
      if (!rxData) since = 0;
      else if (since <= BLANK) lE = 1'h0;
    end
    t = sel < 5 ? int'(sel) : 5;
    dE = 1'h0;
    if (!nrst) begin
      md = 5;
      lastMd = 0;
      since = 1000;
      bcnt = BLINK - 1;
      bph = 1'b0;
    end else if (md != 5 && t != md) begin
      md = 5;
    end else if (md == 5 && t != 5) begin
      keep = (t == 0 || t > 2) && (lastMd == 0 || lastMd > 2);
      dE = t != lastMd && !keep;
      md = t;
      lastMd = t;
    end
    #2;
    if (checkOn) begin
      check(ctrl, ec, "ctrl");
      check(selLines, selExp(md), "mode lines");
      check(drop, dE, "drop");
      check(dtrAcc, dtrE, "dtr");
      check(aae, !vo, "answer");
      check(qOut, eq, "quality");
      check(rdyLamp, rE, "ready lamp");
      check(opLamp, lE, "operate lamp");
    end
  end

  // selector held long enough for blanking to show in loop modes
  task automatic randomPhase(input int n);
    int hold;
    hold = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (hold == 0) begin
        sel = 3'($urandom % 8);
        hold = 5 + $urandom % 60;
      end
      hold--;
      {strap, r1200, dsr, resync, carrier} = 5'($urandom);
      voice = ($urandom % 4) == 0;
      rxData = ($urandom % 40) != 0;
      qIn = 6'($urandom);
    end
  endtask : randomPhase

  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  // hang guard, sized well above the planned run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      nErrors++;
      $display("ERROR %0t timeout", $time);
      completeRun();
    end
  end

  initial begin
    void'($urandom(90));
    {nrst, voice, strap, r1200, dsr, resync, carrier} = 7'h0;
    {rxData, dteOn} = 2'h2;
    sel = 3'h5;
    qIn = 6'h0;
    repeat (20) @(posedge clock);
    #1 nrst = 1'h1;
    repeat (3) @(posedge clock);
    #1 checkOn = 1'b1;
    dteOn = 1'h1;
    randomPhase(4000);
    // second reset in mid run: every output returns to its rest state
    @(posedge clock);
    #1 checkOn = 1'b0;
    nrst = 1'h0;
    repeat (2) @(posedge clock);
    #1;
    check(ctrl, 9'h000, "reset ctrl");
    check(selLines, 6'h10, "reset lines");
    check({drop, aae, dtrAcc, rdyLamp, opLamp}, 5'h00, "reset out");
    check(qOut, 6'h00, "reset quality");
    nrst = 1'h1;
    repeat (3) @(posedge clock);
    #1 checkOn = 1'b1;
    @(posedge clock);
    #1 sel = 3'h0;
    dsr = 1'h1;
    repeat (4) @(posedge clock);
    repeat (2 * BLINK + 6) begin
      @(posedge clock);
      #3;
      if (rdyLamp === 1'h0) seen0 = 1'b1;
      if (rdyLamp === 1'h1) seen1 = 1'b1;
    end
    check({seen0, seen1}, 2'h3, "blink");
    completeRun();
  end
endmodule : modem_test_mode_control_tb

`default_nettype wire
